// file: rtl/pin_cell.sv
// pin_cell: one configurable bidirectional pin cell with APB configuration,
// plus the four dedicated fast pins.
// assumes: fabric signals are on core_clk_i; pins are asynchronous.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pin_cell
(
  // clock, reset, global freeze
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // fabric side
  input wire logic fab_data_i,
  input wire logic fab_oe_i,
  input wire logic fab_ce_i,
  input wire logic fab_aclr_i,
  input wire logic fab_apre_i,
  output logic core_data_o,
  output logic core_fast_data_o,
  // pin side
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  // dedicated fast pins, index 0..3 is fast_pin_one..fast_pin_four
  input wire logic [pin_cell_pkg::FAST_PINS-1:0] fast_pin_i,
  output logic [pin_cell_pkg::FAST_PINS-1:0] fast_pin_o,
  output logic [pin_cell_pkg::FAST_PINS-1:0] fast_pin_oe_n_o,
  input wire logic [pin_cell_pkg::FAST_PINS-1:0] fast_out_i,
  input wire logic [pin_cell_pkg::FAST_PINS-1:0] fast_oe_i,
  output logic [pin_cell_pkg::FAST_PINS-1:0] fast_dist_o
);
  logic [pin_cell_pkg::CTRL_W-1:0] ctrl_reg;
  logic [pin_cell_pkg::DELAY_W-1:0] delay_reg;
  logic [31:0] prdata_reg;
  logic load_reg;
  logic [1:0] pin_sync_reg;
  logic [pin_cell_pkg::FAST_PINS-1:0] fast_meta_reg;
  logic [pin_cell_pkg::FAST_PINS-1:0] fast_sync_reg;
  logic [pin_cell_pkg::FAST_PINS-1:0] fast_out_reg;
  logic [pin_cell_pkg::FAST_PINS-1:0] fast_oe_reg;
  logic pin_q_reg;
  logic pin_q_next;
  logic oe_reg;
  logic in_cap_reg;
  logic [1:0] cfg_dir;
  logic cfg_launch;
  logic cfg_pu;
  logic cfg_enh;
  logic cfg_od;
  logic cfg_nod;
  logic [pin_cell_pkg::INV_W-1:0] cfg_inv;
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_delay;
  logic hit_status;
  logic unmapped;
  logic wr_ctrl;
  logic wr_delay;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic pin_in;
  logic data_in;
  logic oe_in;
  logic ce_in;
  logic clr_in;
  logic aclr_eff;
  logic apre_eff;
  logic [pin_cell_pkg::NUM_DLY-1:0] dly_in;
  logic [pin_cell_pkg::NUM_DLY-1:0] dly_out;
  logic ce_eff;
  logic out_data;
  logic drive_req;
  logic drive_eff;

  // configuration fields
  assign cfg_dir = ctrl_reg[pin_cell_pkg::CTRL_DIR_LSB +: 2];
  assign cfg_launch = ctrl_reg[pin_cell_pkg::CTRL_ROLE_BIT];
  assign cfg_pu = ctrl_reg[pin_cell_pkg::CTRL_PU_BIT];
  assign cfg_enh = ctrl_reg[pin_cell_pkg::CTRL_ENH_BIT];
  assign cfg_od = ctrl_reg[pin_cell_pkg::CTRL_OD_BIT];
  assign cfg_nod = ctrl_reg[pin_cell_pkg::CTRL_NOD_BIT] & cfg_enh;
  assign cfg_inv = ctrl_reg[pin_cell_pkg::CTRL_INV_LSB +: pin_cell_pkg::INV_W];

  // apb decode
  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign hit_ctrl = paddr_i == pin_cell_pkg::CTRL_OFS;
  assign hit_delay = paddr_i == pin_cell_pkg::DELAY_OFS;
  assign hit_status = paddr_i == pin_cell_pkg::STATUS_OFS;
  assign unmapped = ~(hit_ctrl | hit_delay | hit_status);
  assign wr_ctrl = access_phase & pwrite_i & hit_ctrl;
  assign wr_delay = access_phase & pwrite_i & hit_delay;
  // zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = access_phase & unmapped;
  assign prdata_o = prdata_reg;

  assign status_word = {{(32 - pin_cell_pkg::STAT_FAST_LSB - pin_cell_pkg::FAST_PINS){1'b0}},
    fast_sync_reg, drive_eff, pin_q_reg, pin_in};
  assign rd_mux = hit_ctrl ? {{(32 - pin_cell_pkg::CTRL_W){1'b0}}, ctrl_reg} :
    hit_delay ? {{(32 - pin_cell_pkg::DELAY_W){1'b0}}, delay_reg} :
    hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= pin_cell_pkg::CTRL_RESET;
      delay_reg <= pin_cell_pkg::DELAY_RESET;
      prdata_reg <= 32'h0000_0000;
      load_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata_i[pin_cell_pkg::CTRL_W-1:0];
      if (wr_delay)
        delay_reg <= pwdata_i[pin_cell_pkg::DELAY_W-1:0];
      // latched in setup so read data stands through the access phase
      if (setup_phase)
        prdata_reg <= rd_mux;
      load_reg <= wr_ctrl;
    end
  end

  // pin and fast pin synchronisers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_sync_reg <= 2'h0;
      fast_meta_reg <= '0;
      fast_sync_reg <= '0;
    end
    else if (ce_i)
    begin
      pin_sync_reg <= {pin_sync_reg[0], pin_i};
      fast_meta_reg <= fast_pin_i;
      fast_sync_reg <= fast_meta_reg;
    end
  end
  assign pin_in = pin_sync_reg[1];

  // routed fabric signals, optionally inverted
  assign data_in = fab_data_i ^ cfg_inv[pin_cell_pkg::INV_DATA];
  assign oe_in = fab_oe_i ^ cfg_inv[pin_cell_pkg::INV_OE];
  assign ce_in = fab_ce_i ^ cfg_inv[pin_cell_pkg::INV_CE];
  assign clr_in = fab_aclr_i ^ cfg_inv[pin_cell_pkg::INV_CLR];

  // delay chain inputs, one per path
  assign dly_in[pin_cell_pkg::DLY_PIN_CORE] = pin_in;
  assign dly_in[pin_cell_pkg::DLY_PIN_INREG] = pin_in;
  assign dly_in[pin_cell_pkg::DLY_CORE_OUTREG] = data_in;
  assign dly_in[pin_cell_pkg::DLY_OUTREG_PIN] = cfg_launch ? pin_q_reg : data_in;
  assign dly_in[pin_cell_pkg::DLY_CE] = ce_in;

  genvar gi;
  generate
    for (gi = 0; gi < pin_cell_pkg::NUM_DLY; gi++)
    begin : g_dly
      logic [pin_cell_pkg::DLY_SEL_W-1:0] sel;
      // clock enable delay exists only in the enhanced cell
      assign sel = (gi == pin_cell_pkg::DLY_CE && !cfg_enh) ? pin_cell_pkg::DLY_OFF :
        delay_reg[gi*pin_cell_pkg::DLY_SEL_W +: pin_cell_pkg::DLY_SEL_W];
      delay_chain u_dly
      (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .enh_i(cfg_enh),
        .sel_i(sel),
        .d_i(dly_in[gi]),
        .q_o(dly_out[gi])
      );
    end
  endgenerate

  assign ce_eff = dly_out[pin_cell_pkg::DLY_CE];

  // gated combinationally: fabric clear and preset must be glitch free
  // async controls by start value and variant
  assign aclr_eff = clr_in & ~cfg_pu;
  assign apre_eff = fab_apre_i & cfg_pu & cfg_enh;

  // capture from pin or launch from core
  assign pin_q_next = cfg_launch ? dly_out[pin_cell_pkg::DLY_CORE_OUTREG] : dly_out[pin_cell_pkg::DLY_PIN_INREG];

  always_ff @(posedge core_clk_i or posedge aclr_eff or posedge apre_eff)
  begin
    if (aclr_eff)
      pin_q_reg <= 1'b0;
    else if (apre_eff)
      pin_q_reg <= 1'b1;
    else if (rst_i || (ce_i && load_reg))
      pin_q_reg <= cfg_pu;
    else if (ce_i && ce_eff)
      pin_q_reg <= pin_q_next;
  end

  // output enable and fast capture registers beside the pin
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      oe_reg <= 1'b0;
      in_cap_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      oe_reg <= oe_in;
      in_cap_reg <= dly_out[pin_cell_pkg::DLY_PIN_CORE];
    end
  end
  assign core_fast_data_o = in_cap_reg;

  // input path sees the pin in launch role, the capture register otherwise
  assign core_data_o = cfg_launch ? dly_out[pin_cell_pkg::DLY_PIN_CORE] : pin_q_reg;

  // direction and per-pin output enable
  assign out_data = dly_out[pin_cell_pkg::DLY_OUTREG_PIN];
  assign drive_req = (cfg_dir == pin_cell_pkg::DIR_OUTPUT) |
    ((cfg_dir == pin_cell_pkg::DIR_BIDIR) & oe_reg);
  // open-drain: enable only while data is low, native or emulated
  assign drive_eff = (cfg_od | cfg_nod) ? (drive_req & ~out_data) : drive_req;
  assign pin_o = (cfg_od | cfg_nod) ? 1'b0 : out_data;
  assign pin_oe_n_o = ~drive_eff;

  // same-clock local routing: drive registered once, no synchroniser
  // fast pins: inward distribution and outward drive from local routing
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      fast_out_reg <= '0;
      fast_oe_reg <= '0;
    end
    else if (ce_i)
    begin
      fast_out_reg <= fast_out_i;
      fast_oe_reg <= fast_oe_i;
    end
  end
  assign fast_dist_o = fast_sync_reg;
  assign fast_pin_o = fast_out_reg;
  assign fast_pin_oe_n_o = ~fast_oe_reg;

  // checks
  // reset edge excluded where flops still load reset values at release
  property p_od_low;
    @(posedge core_clk_i) disable iff (rst_i)
      (cfg_od | cfg_nod) |-> (pin_o == 1'b0);
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");

  property p_input_only;
    @(posedge core_clk_i) disable iff (rst_i)
      (cfg_dir == pin_cell_pkg::DIR_INPUT) |-> pin_oe_n_o;
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only pin drives");

  property p_bidir_oe;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && !wr_ctrl && cfg_dir == pin_cell_pkg::DIR_BIDIR && !cfg_od && !cfg_nod && $stable(ctrl_reg))
        |=> (pin_oe_n_o == !$past(oe_in));
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("bidir enable not from enable register");

  property p_clear;
    @(posedge core_clk_i) disable iff (rst_i)
      aclr_eff |-> (pin_q_reg == 1'b0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty register");

  property p_preset;
    @(posedge core_clk_i) disable iff (rst_i)
      apre_eff |-> (pin_q_reg == 1'b1);
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not set register");

  property p_base_high_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      (!cfg_enh && cfg_pu && !ce_eff && !load_reg && $stable(ctrl_reg)) |=> $stable(pin_q_reg);
  endproperty
  a_base_high_hold: assert property (p_base_high_hold) else $error("base start-high register moved");

  property p_ce_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      (!rst_i && !(ce_i && ce_eff) && !load_reg && !aclr_eff && !apre_eff)
        |=> ($stable(pin_q_reg) || aclr_eff || apre_eff);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("register moved without clock enable");

  property p_load_start;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && wr_ctrl) ##1 (ce_i && !aclr_eff && !apre_eff) ##1 (!aclr_eff && !apre_eff) |-> (pin_q_reg == cfg_pu);
  endproperty
  a_load_start: assert property (p_load_start) else $error("start value not loaded");

  property p_pin_visible;
    @(posedge core_clk_i) disable iff (rst_i)
      ((ce_i && !rst_i) [*3]) |-> (pin_in == $past(pin_i, 2));
  endproperty
  a_pin_visible: assert property (p_pin_visible) else $error("pin data lost on input path");

  property p_fast_out;
    @(posedge core_clk_i) disable iff (rst_i)
      (ce_i && !rst_i) |=> (fast_pin_o == $past(fast_out_i)) && (fast_pin_oe_n_o == ~$past(fast_oe_i));
  endproperty
  a_fast_out: assert property (p_fast_out) else $error("fast pin drive mismatch");

  property p_inv_data;
    @(posedge core_clk_i) disable iff (rst_i)
      (delay_reg == pin_cell_pkg::DELAY_RESET && !cfg_launch && !cfg_od && !cfg_nod)
        |-> (pin_o == (fab_data_i ^ cfg_inv[pin_cell_pkg::INV_DATA]));
  endproperty
  a_inv_data: assert property (p_inv_data) else $error("data inversion wrong");
endmodule

// file: rtl/pin_cell_pkg.sv
// pin_cell_pkg: register map, field layout and fixed sizes of the pin cell.
// assumes: APB slave with 12-bit byte address and 32-bit data.
package pin_cell_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DELAY_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  // control field layout
  localparam int CTRL_DIR_LSB = 0;
  localparam int CTRL_ROLE_BIT = 2;
  localparam int CTRL_PU_BIT = 3;
  localparam int CTRL_ENH_BIT = 4;
  localparam int CTRL_OD_BIT = 5;
  localparam int CTRL_NOD_BIT = 6;
  localparam int CTRL_INV_LSB = 7;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  // direction encodings
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_OUTPUT = 2'h1;
  localparam logic [1:0] DIR_BIDIR = 2'h2;
  // inversion mask bit positions
  localparam int INV_DATA = 0;
  localparam int INV_OE = 1;
  localparam int INV_CE = 2;
  localparam int INV_CLR = 3;
  localparam int INV_W = 4;
  // delay chains
  localparam int DLY_SEL_W = 2;
  localparam int NUM_DLY = 5;
  localparam int DLY_TAPS = 3;
  localparam int DELAY_W = 10;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 10'h000;
  localparam logic [DLY_SEL_W-1:0] DLY_OFF = 2'h0;
  localparam logic [DLY_SEL_W-1:0] DLY_ONE = 2'h1;
  localparam int DLY_PIN_CORE = 0;
  localparam int DLY_PIN_INREG = 1;
  localparam int DLY_CORE_OUTREG = 2;
  localparam int DLY_OUTREG_PIN = 3;
  localparam int DLY_CE = 4;
  // status layout
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_Q_BIT = 1;
  localparam int STAT_DRV_BIT = 2;
  localparam int STAT_FAST_LSB = 3;
  // dedicated fast pins
  localparam int FAST_PINS = 4;
endpackage

// file: rtl/delay_chain.sv
// delay_chain: selectable delay of one signal by whole clock cycles.
// assumes: sel is static configuration; base cell offers one level only.
`timescale 1ns/1ps
module delay_chain
(
  // clock and control
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire logic enh_i,
  input wire logic [pin_cell_pkg::DLY_SEL_W-1:0] sel_i,
  // data
  input wire logic d_i,
  output logic q_o
);
  logic [pin_cell_pkg::DLY_TAPS-1:0] tap_reg;
  logic [pin_cell_pkg::DLY_SEL_W-1:0] sel_eff;

  // base cell: any nonzero setting is the single level
  assign sel_eff = (enh_i || sel_i == pin_cell_pkg::DLY_OFF) ? sel_i : pin_cell_pkg::DLY_ONE;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      tap_reg <= '0;
    else if (ce_i)
      tap_reg <= {tap_reg[pin_cell_pkg::DLY_TAPS-2:0], d_i};
  end

  assign q_o = (sel_eff == pin_cell_pkg::DLY_OFF) ? d_i : tap_reg[sel_eff - pin_cell_pkg::DLY_ONE];
endmodule

// file: sim/pin_board.sv
// pin_board: board side of the cell pin and the four fast pins.
// assumes: pull-up on the cell pin line, board drives it only when enabled; released fast lines take fast_ext_i.
`timescale 1ns/1ps
module pin_board
(
  // cell drive
  input wire logic cell_out_i,
  input wire logic cell_oe_n_i,
  input wire logic [3:0] fast_out_i,
  input wire logic [3:0] fast_oe_n_i,
  // board drive
  input wire logic ext_en_i,
  input wire logic ext_val_i,
  input wire logic [3:0] fast_ext_i,
  // line levels
  output logic level_o,
  output logic [3:0] fast_level_o
);
  // released line rises through its pull-up
  assign level_o = !cell_oe_n_i ? cell_out_i : (ext_en_i ? ext_val_i : 1'h1);
  assign fast_level_o = (fast_out_i & ~fast_oe_n_i) | (fast_ext_i & fast_oe_n_i);
endmodule

// file: sim/testbench.sv
// testbench: directed scenarios for the pin cell over APB and its pins.
// assumes: pin_board resolves line levels; ce_i dropped once to check the freeze.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fab_data = 1'h0, fab_oe = 1'h0, fab_ce = 1'h0;
  logic aclr = 1'h0, apre = 1'h0, ext_en = 1'h0, ext_val = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] fast_out = 4'h0, fast_oe = 4'h0, fast_ext = 4'h0, fast_in, fast_pin, fast_oe_n, fast_dist;
  logic pready, pslverr, core_data, core_fast, pin_in, pin_out, pin_oe_n;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;

  pin_cell DUT (.core_clk_i(core_clk), .rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .fab_data_i(fab_data), .fab_oe_i(fab_oe), .fab_ce_i(fab_ce),
    .fab_aclr_i(aclr), .fab_apre_i(apre), .core_data_o(core_data), .core_fast_data_o(core_fast),
    .pin_i(pin_in), .pin_o(pin_out), .pin_oe_n_o(pin_oe_n), .fast_pin_i(fast_in), .fast_pin_o(fast_pin),
    .fast_pin_oe_n_o(fast_oe_n), .fast_out_i(fast_out), .fast_oe_i(fast_oe), .fast_dist_o(fast_dist));

  pin_board board (.cell_out_i(pin_out), .cell_oe_n_i(pin_oe_n), .fast_out_i(fast_pin),
    .fast_oe_n_i(fast_oe_n), .ext_en_i(ext_en), .ext_val_i(ext_val), .fast_ext_i(fast_ext),
    .level_o(pin_in), .fast_level_o(fast_in));

  initial forever #4 core_clk = ~core_clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic ctl(input logic [31:0] d);
    apb(1'h1, pin_cell_pkg::CTRL_OFS, d);
  endtask

  task automatic stat(input logic [31:0] mask, input logic [31:0] exp, input string name);
    apb(1'h0, pin_cell_pkg::STATUS_OFS, 32'h0);
    chk(name, rd & mask, exp);
  endtask

  // cycles until the input path shows a new line level
  task automatic lat(input logic v, output int n);
    n = 0;
    ext_val <= v;
    step(1);
    while (core_data !== v && n < 20)
    begin
      n++;
      step(1);
    end
  endtask

  task automatic t_reset();
    apb(1'h0, pin_cell_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    chk("mapped err", err, 1'h0);
    chk("idle oe_n", pin_oe_n, 1'h1);
    chk("fast oe_n", fast_oe_n, 4'hf);
    apb(1'h0, 12'h00c, 32'h0);
    chk("unmapped err", err, 1'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  task automatic t_capture();
    fab_oe <= 1'h1;
    ctl(32'h0000_0008);
    stat(32'h2, 32'h2, "start high");
    aclr <= 1'h1;
    stat(32'h2, 32'h2, "clear ignored");
    aclr <= 1'h0;
    ctl(32'h0000_0000);
    stat(32'h2, 32'h0, "start low");
    ext_en <= 1'h1;
    ext_val <= 1'h1;
    fab_ce <= 1'h1;
    step(6);
    stat(32'h3, 32'h3, "capture");
    chk("core data", core_data, 1'h1);
    chk("input only", pin_oe_n, 1'h1);
    fab_ce <= 1'h0;
    ext_val <= 1'h0;
    step(6);
    stat(32'h3, 32'h2, "hold");
    aclr <= 1'h1;
    step(2);
    stat(32'h2, 32'h0, "async clear");
    aclr <= 1'h0;
  endtask

  task automatic t_preset();
    for (int e = 0; e < 2; e++)
    begin
      ctl(e ? 32'h18 : 32'h08);
      fab_ce <= 1'h1;
      step(6);
      fab_ce <= 1'h0;
      apre <= 1'h1;
      step(2);
      stat(32'h2, e ? 32'h2 : 32'h0, "preset");
      apre <= 1'h0;
    end
  endtask

  task automatic t_launch();
    ctl(32'h0000_0085);
    fab_data <= 1'h0;
    fab_ce <= 1'h1;
    step(6);
    chk("drive en", pin_oe_n, 1'h0);
    chk("launch", pin_out, 1'h1);
    fab_data <= 1'h1;
    step(6);
    chk("launch", pin_out, 1'h0);
  endtask

  task automatic t_od();
    ext_en <= 1'h0;
    for (int k = 0; k < 2; k++)
    begin
      ctl(k ? 32'h55 : 32'h25);
      fab_data <= 1'h1;
      step(6);
      chk("od release", pin_oe_n, 1'h1);
      chk("od data", pin_out, 1'h0);
      chk("line", pin_in, 1'h1);
      fab_data <= 1'h0;
      step(6);
      chk("od pull", pin_oe_n, 1'h0);
    end
  endtask

  task automatic t_bidir();
    ctl(32'h0000_0006);
    ext_en <= 1'h1;
    fab_oe <= 1'h0;
    ext_val <= 1'h0;
    step(6);
    chk("bidir off", pin_oe_n, 1'h1);
    chk("fast cap off", core_fast, 1'h0);
    chk("in path", core_data, 1'h0);
    ext_val <= 1'h1;
    step(6);
    chk("in path", core_data, 1'h1);
    chk("fast cap on", core_fast, 1'h1);
    fab_oe <= 1'h1;
    step(3);
    chk("bidir on", pin_oe_n, 1'h0);
    fab_oe <= 1'h0;
  endtask

  task automatic t_delay();
    int n0;
    int n;
    n0 = 0;
    for (int e = 0; e < 2; e++)
      for (int s = 0; s < 4; s++)
      begin
        ctl(e ? 32'h16 : 32'h06);
        apb(1'h1, pin_cell_pkg::DELAY_OFS, 32'hffff_fc00 | s);
        apb(1'h0, pin_cell_pkg::DELAY_OFS, 32'h0);
        chk("delay reg", rd, s);
        ext_val <= 1'h0;
        step(8);
        lat(1'h1, n);
        if (s == 0)
          n0 = n;
        else
          chk("extra delay", n - n0, e ? s : 1);
      end
  endtask

  task automatic t_fast();
    fast_out <= 4'h6;
    fast_oe <= 4'h3;
    fast_ext <= 4'h9;
    step(5);
    chk("fast out", fast_pin, 4'h6);
    chk("fast oe_n", fast_oe_n, 4'hc);
    chk("fast in", fast_dist, 4'ha);
    stat(32'h78, 32'h50, "fast status");
  endtask

  // inverted enable, clock enable and clear; direction code 3; global freeze
  task automatic t_inv();
    fab_ce <= 1'h0;
    ctl(32'h0000_0106);
    step(3);
    chk("inv oe", pin_oe_n, 1'h0);
    ext_val <= 1'h1;
    ctl(32'h0000_0303);
    step(6);
    chk("inv ce", core_data, 1'h1);
    chk("dir 3 input", pin_oe_n, 1'h1);
    ce <= 1'h0;
    ext_val <= 1'h0;
    fast_out <= 4'h9;
    step(6);
    chk("freeze", core_data, 1'h1);
    chk("freeze fast", fast_pin, 4'h6);
    ce <= 1'h1;
    step(6);
    chk("thaw", core_data, 1'h0);
    chk("thaw fast", fast_pin, 4'h9);
    ext_val <= 1'h1;
    step(6);
    ctl(32'h0000_0703);
    step(6);
    chk("inv clear", core_data, 1'h0);
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_capture();
    t_preset();
    t_launch();
    t_od();
    t_bidir();
    t_delay();
    t_fast();
    t_inv();
    test_done();
  end
endmodule
